// [hw/bslse_regs.svh]
// Purpose: Shared constants for the branch, skip, load and store execution core.
// Assumes: 16-bit instruction words; 8-bit data; 16-bit data address space.
// Notes: Opcode patterns are given as mask and match pairs.
// Functional notes
// RL1: Skip next instruction when selected general register bit is one; 1/2/3 cycles.
// RL2: Skip next instruction when selected general register bit is zero; 1/2/3 cycles.
// RL3: I/O bit skips test an I/O register bit, zero or one form.
// RL4: Skip passes the whole next instruction, one word or two words.
// RL5: Generic branch tests any flag bit; taken loads PC plus offset plus one. The code tests N xor V instead of flag bit 4 when bit 4 is selected.
// RL6: Untaken branch uses one cycle; taken branch uses two cycles.
// RL7: Equal branch on zero flag one; not-equal branch on zero flag zero.
// RL8: Carry-set and lower branch on carry one; clear and same-or-higher on zero.
// RL9: Minus branch on negative flag one; plus branch on negative flag zero.
// RL10: Signed greater-or-equal on N xor V zero; signed less-than on one.
// RL11: Half-carry branches on half-carry flag one or zero.
// RL12: Transfer-bit branches on spare transfer flag one or zero.
// RL13: Overflow branches on overflow flag one or zero.
// RL14: Interrupt-state branches on global interrupt enable flag one or zero.
// RL15: Indirect load reads memory at pointer; post-increment adds one; two cycles.
// RL16: Pre-decrement load subtracts one from pointer, then reads; two cycles.
// RL17: Displaced load reads pointer plus displacement; pointer unchanged; two cycles.
// RL18: Direct load reads memory at the address word of the instruction; two cycles.
// RL19: Post-increment store writes source at pointer, then adds one; two cycles.
// RL20: Pre-decrement store subtracts one from pointer, then writes; two cycles.
`ifndef BSLSE_REGS_SVH
`define BSLSE_REGS_SVH
`define BSLSE_PC_RST      16'h0000
`define BSLSE_FLAG_C      3'h0
`define BSLSE_FLAG_Z      3'h1
`define BSLSE_FLAG_N      3'h2
`define BSLSE_FLAG_V      3'h3
`define BSLSE_FLAG_S      3'h4
`define BSLSE_PTR_BASE    5'h1a
`define BSLSE_M_SKIP_GPR  16'hfc08
`define BSLSE_V_SKIP_GPR  16'hfc00
`define BSLSE_M_SKIP_IO   16'hfd00
`define BSLSE_V_SKIP_IO   16'h9900
`define BSLSE_M_BRANCH    16'hf800
`define BSLSE_V_BRANCH    16'hf000
`define BSLSE_M_COPY      16'hfc00
`define BSLSE_V_COPY      16'h2c00
`define BSLSE_M_PAIR      16'hff00
`define BSLSE_V_PAIR      16'h0100
`define BSLSE_M_IMM       16'hf000
`define BSLSE_V_IMM       16'he000
`define BSLSE_M_LDST      16'hfc00
`define BSLSE_V_LDST      16'h9000
`define BSLSE_M_DISP      16'hd000
`define BSLSE_V_DISP      16'h8000
`define BSLSE_M_FAR       16'hfc0c
`define BSLSE_V_FAR       16'h940c
`define BSLSE_M_DIRECT    16'hfc0f
`define BSLSE_V_DIRECT    16'h9000
`endif

// [hw/bslse_pkg.sv]
// Purpose: Types shared by the execution core and its decoder.
// Assumes: Constants come from the shared header.
// Notes: The two-word test is used by the skip logic and by its assertion.
`include "bslse_regs.svh"
package bslse_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_SKIP_GPR, OP_SKIP_IO, OP_BRANCH, OP_COPY, OP_PAIR_COPY, OP_IMM,
        OP_LOAD, OP_STORE
    } bslse_op_t;
    typedef enum logic [1:0] {AM_PTR, AM_DISP, AM_DIRECT} bslse_amode_t;
    typedef enum logic [1:0] {PM_PLAIN, PM_INC, PM_DEC} bslse_pmode_t;
    function automatic logic bslse_two_word(input logic [15:0] w);
        bslse_two_word = ((w & `BSLSE_M_FAR) == `BSLSE_V_FAR) ||
                         ((w & `BSLSE_M_DIRECT) == `BSLSE_V_DIRECT);
    endfunction
endpackage

// [hw/bslse_dec_if.sv]
// Purpose: Decoded instruction fields passed from the decoder to the core.
// Assumes: One decoder drives, the core and condition unit read.
// Notes: All fields are combinational from the current instruction word.
`timescale 1ns/1ps
interface bslse_dec_if import bslse_pkg::*; ();
    bslse_op_t    op;
    bslse_amode_t amode;
    bslse_pmode_t pmode;
    logic [4:0]   rd;
    logic [4:0]   rr;
    logic [2:0]   bsel;
    logic         pol;
    logic [6:0]   koff;
    logic [5:0]   disp;
    logic [1:0]   ptr;
    logic [4:0]   ioa;
    logic [7:0]   imm;
    modport dec (output op, amode, pmode, rd, rr, bsel, pol, koff, disp, ptr, ioa, imm);
    modport exe (input op, amode, pmode, rd, rr, bsel, pol, koff, disp, ptr, ioa, imm);
    modport cnd (input op, bsel, pol);
endinterface

// [hw/bslse_decode.sv]
// Purpose: Splits an instruction word into operation class and operand fields.
// Assumes: Words outside this group decode to OP_NONE.
// Notes: Plain pointer loads through the second and third pairs use the displaced form.
`timescale 1ns/1ps
`include "bslse_regs.svh"
module bslse_decode import bslse_pkg::*; (
    input  wire logic [15:0] inst,
    bslse_dec_if.dec         d
);
    always_comb begin
        d.op    = OP_NONE;
        d.amode = AM_PTR;
        d.pmode = PM_PLAIN;
        d.rd    = inst[8:4];
        d.rr    = {inst[9], inst[3:0]};
        d.bsel  = inst[2:0];
        d.pol   = inst[9];
        d.koff  = inst[9:3];
        d.disp  = {inst[13], inst[11:10], inst[2:0]};
        d.ptr   = 2'h0;
        d.ioa   = inst[7:3];
        d.imm   = {inst[11:8], inst[3:0]};
        if ((inst & `BSLSE_M_SKIP_GPR) == `BSLSE_V_SKIP_GPR) begin
            d.op = OP_SKIP_GPR;
            d.rr = inst[8:4];
        end else if ((inst & `BSLSE_M_SKIP_IO) == `BSLSE_V_SKIP_IO) begin
            d.op = OP_SKIP_IO;
        end else if ((inst & `BSLSE_M_BRANCH) == `BSLSE_V_BRANCH) begin
            d.op  = OP_BRANCH;
            d.pol = ~inst[10];
        end else if ((inst & `BSLSE_M_COPY) == `BSLSE_V_COPY) begin
            d.op = OP_COPY;
        end else if ((inst & `BSLSE_M_PAIR) == `BSLSE_V_PAIR) begin
            d.op = OP_PAIR_COPY;
            d.rd = {inst[7:4], 1'b0};
            d.rr = {inst[3:0], 1'b0};
        end else if ((inst & `BSLSE_M_IMM) == `BSLSE_V_IMM) begin
            d.op = OP_IMM;
            d.rd = {1'b1, inst[7:4]};
        end else if ((inst & `BSLSE_M_LDST) == `BSLSE_V_LDST) begin
            d.op    = inst[9] ? OP_STORE : OP_LOAD;
            d.ptr   = (inst[3:2] == 2'h3) ? 2'h0 : (inst[3] ? 2'h1 : 2'h2);
            d.pmode = (inst[1:0] == 2'h1) ? PM_INC : PM_DEC;
            if (inst[3:0] == 4'h0) begin
                d.amode = AM_DIRECT;
            end else if (inst[3:0] == 4'hc) begin
                d.pmode = PM_PLAIN;
            end else if (inst[1:0] == 2'h0 || inst[1:0] == 2'h3 || inst[3:2] == 2'h1) begin
                d.op = OP_NONE;
            end
        end else if ((inst & `BSLSE_M_DISP) == `BSLSE_V_DISP) begin
            d.op    = inst[9] ? OP_STORE : OP_LOAD;
            d.amode = AM_DISP;
            d.ptr   = inst[3] ? 2'h1 : 2'h2;
        end
    end
endmodule

// [hw/bslse_cond.sv]
// Purpose: Evaluates the skip and branch conditions of the current instruction.
// Assumes: Flag word bits follow the order C Z N V S H T I from bit zero.
// Notes: Named branches are the generic forms with a fixed flag selector.
`timescale 1ns/1ps
`include "bslse_regs.svh"
module bslse_cond import bslse_pkg::*; (
    bslse_dec_if.cnd         d,
    input  wire logic [7:0]  flags,
    input  wire logic [7:0]  gpr_val,
    input  wire logic [7:0]  io_val,
    output logic             hit
);
    logic flag_bit;
    always_comb begin
        flag_bit = flags[d.bsel]; // [RL5] [RL7] [RL8] [RL9] [RL11] [RL12] [RL13] [RL14]
        // The sign test is formed from N and V so it never depends on a stale S bit.
        if (d.bsel == `BSLSE_FLAG_S) begin
            flag_bit = flags[`BSLSE_FLAG_N] ^ flags[`BSLSE_FLAG_V]; // [RL10]
        end
        case (d.op)
            OP_SKIP_GPR: hit = (gpr_val[d.bsel] == d.pol); // [RL1] [RL2]
            OP_SKIP_IO:  hit = (io_val[d.bsel] == d.pol); // [RL3]
            OP_BRANCH:   hit = (flag_bit == d.pol); // [RL5]
            default:     hit = 1'b0;
        endcase
    end
endmodule

// [hw/bslse_core.sv]
// Purpose: Executes skips, conditional branches, register copies, loads and stores.
// Assumes: Program memory reads combinationally at pm_addr and pm_addr plus one;
//          data memory reads combinationally and writes at the clock edge.
// Notes: The general register file lives here; flags come from outside.
`timescale 1ns/1ps
`include "bslse_regs.svh"
module bslse_core import bslse_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    output logic [15:0]      pm_addr,
    input  wire logic [15:0] pm_word,
    input  wire logic [15:0] pm_next,
    input  wire logic [7:0]  cpu_flag_word,
    output logic [4:0]       io_addr,
    input  wire logic [7:0]  io_rdata,
    output logic [15:0]      dm_addr,
    output logic [7:0]       dm_wdata,
    output logic             dm_we,
    output logic             dm_re,
    input  wire logic [7:0]  dm_rdata,
    input  wire logic [4:0]  dbg_sel,
    output logic [7:0]       dbg_data,
    output logic             unknown_op
);
    typedef enum logic [2:0] {ST_EXEC, ST_SKIP, ST_SKIP2, ST_BRANCH, ST_MEM} bslse_state_t;

    bslse_state_t state_q;
    logic [15:0]  pc_q;
    logic [7:0]   rf [32];
    logic [15:0]  dm_addr_q;
    logic [7:0]   dm_wdata_q;
    logic         dm_we_q;
    logic         dm_re_q;
    logic         load_q;
    logic         direct_q;
    logic         ptr_wr_q;
    logic [4:0]   ptr_idx_q;
    logic [15:0]  ptr_new_q;
    logic [4:0]   ld_rd_q;
    logic [7:0]   dbg_q;
    logic         unknown_q;
    logic         cond_hit;
    logic [7:0]   gpr_src;
    logic [4:0]   ptr_idx;
    logic [15:0]  ptr_val;
    logic [15:0]  koff_ext;
    logic [15:0]  mem_addr_d;
    logic [15:0]  ptr_new_d;
    logic         exec;

    bslse_dec_if dif ();

    bslse_decode u_dec (
        .inst (pm_word),
        .d    (dif)
    );

    bslse_cond u_cnd (
        .d       (dif),
        .flags   (cpu_flag_word),
        .gpr_val (gpr_src),
        .io_val  (io_rdata),
        .hit     (cond_hit)
    );

    assign exec     = (state_q == ST_EXEC);
    assign gpr_src  = rf[dif.rr];
    assign ptr_idx  = `BSLSE_PTR_BASE + {2'h0, dif.ptr, 1'b0};
    assign ptr_val  = {rf[ptr_idx + 5'h01], rf[ptr_idx]};
    assign koff_ext = {{9{dif.koff[6]}}, dif.koff};
    // The I/O address follows the decoder directly so the bit test needs no extra cycle.
    assign io_addr  = dif.ioa;

    // Address of the data access and the pointer value left behind by it.
    always_comb begin
        ptr_new_d = ptr_val;
        case (dif.amode)
            AM_DISP:   mem_addr_d = ptr_val + {10'h000, dif.disp}; // [RL17]
            AM_DIRECT: mem_addr_d = pm_next; // [RL18]
            default: begin
                if (dif.pmode == PM_DEC) begin
                    mem_addr_d = ptr_val - 16'h0001; // [RL16] [RL20]
                    ptr_new_d  = ptr_val - 16'h0001;
                end else begin
                    mem_addr_d = ptr_val; // [RL15]
                    ptr_new_d  = ptr_val + 16'h0001; // [RL15] [RL19]
                end
            end
        endcase
    end

    // Sequencing and program counter.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_EXEC;
            pc_q    <= `BSLSE_PC_RST;
        end else begin
            case (state_q)
                ST_EXEC: begin
                    case (dif.op)
                        OP_SKIP_GPR, OP_SKIP_IO: begin
                            pc_q <= pc_q + 16'h0001;
                            if (cond_hit) begin
                                state_q <= ST_SKIP; // [RL1] [RL2] [RL3]
                            end
                        end
                        OP_BRANCH: begin
                            if (cond_hit) begin
                                pc_q    <= pc_q + koff_ext + 16'h0001; // [RL5]
                                state_q <= ST_BRANCH; // [RL6]
                            end else begin
                                pc_q <= pc_q + 16'h0001; // [RL6]
                            end
                        end
                        OP_LOAD, OP_STORE: begin
                            state_q <= ST_MEM;
                        end
                        default: begin
                            pc_q <= pc_q + 16'h0001;
                        end
                    endcase
                end
                ST_SKIP: begin
                    // The word now at pm_addr is the one being passed over.
                    pc_q    <= pc_q + 16'h0001;
                    state_q <= bslse_two_word(pm_word) ? ST_SKIP2 : ST_EXEC; // [RL4]
                end
                ST_SKIP2: begin
                    pc_q    <= pc_q + 16'h0001; // [RL4]
                    state_q <= ST_EXEC;
                end
                ST_BRANCH: begin
                    state_q <= ST_EXEC;
                end
                ST_MEM: begin
                    pc_q    <= pc_q + (direct_q ? 16'h0002 : 16'h0001); // [RL18]
                    state_q <= ST_EXEC;
                end
                default: begin
                    state_q <= ST_EXEC;
                end
            endcase
        end
    end

    // Data memory strobes and the pending pointer and load write-back.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_addr_q  <= 16'h0000;
            dm_wdata_q <= 8'h00;
            dm_we_q    <= 1'b0;
            dm_re_q    <= 1'b0;
            load_q     <= 1'b0;
            direct_q   <= 1'b0;
            ptr_wr_q   <= 1'b0;
            ptr_idx_q  <= 5'h00;
            ptr_new_q  <= 16'h0000;
            ld_rd_q    <= 5'h00;
        end else if (exec && (dif.op == OP_LOAD || dif.op == OP_STORE)) begin
            dm_addr_q  <= mem_addr_d;
            dm_wdata_q <= rf[dif.rd]; // [RL19] [RL20]
            dm_we_q    <= (dif.op == OP_STORE);
            dm_re_q    <= (dif.op == OP_LOAD);
            load_q     <= (dif.op == OP_LOAD);
            direct_q   <= (dif.amode == AM_DIRECT);
            ptr_wr_q   <= (dif.amode == AM_PTR) && (dif.pmode != PM_PLAIN); // [RL17]
            ptr_idx_q  <= ptr_idx;
            ptr_new_q  <= ptr_new_d;
            ld_rd_q    <= dif.rd;
        end else begin
            dm_we_q  <= 1'b0;
            dm_re_q  <= 1'b0;
            load_q   <= 1'b0;
            ptr_wr_q <= 1'b0;
        end
    end

    // General register file. A load into a pointer register overrides the pointer update.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 32; i++) begin
                rf[i] <= 8'h00;
            end
        end else if (exec) begin
            case (dif.op)
                OP_COPY: begin
                    rf[dif.rd] <= gpr_src;
                end
                OP_PAIR_COPY: begin
                    rf[dif.rd]          <= rf[dif.rr];
                    rf[dif.rd + 5'h01]  <= rf[dif.rr + 5'h01];
                end
                OP_IMM: begin
                    rf[dif.rd] <= dif.imm;
                end
                default: begin
                end
            endcase
        end else if (state_q == ST_MEM) begin
            if (ptr_wr_q) begin
                rf[ptr_idx_q]         <= ptr_new_q[7:0]; // [RL15] [RL16] [RL19] [RL20]
                rf[ptr_idx_q + 5'h01] <= ptr_new_q[15:8];
            end
            if (load_q) begin
                rf[ld_rd_q] <= dm_rdata; // [RL15] [RL18]
            end
        end
    end

    // Observation and status outputs.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dbg_q     <= 8'h00;
            unknown_q <= 1'b0;
        end else begin
            dbg_q     <= rf[dbg_sel];
            unknown_q <= exec && (dif.op == OP_NONE);
        end
    end

    assign pm_addr    = pc_q;
    assign dm_addr    = dm_addr_q;
    assign dm_wdata   = dm_wdata_q;
    assign dm_we      = dm_we_q;
    assign dm_re      = dm_re_q;
    assign dbg_data   = dbg_q;
    assign unknown_op = unknown_q;

    property p_skip_gpr_one;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_SKIP_GPR && dif.pol && gpr_src[dif.bsel])
        |=> (state_q == ST_SKIP) && (pc_q == $past(pc_q) + 16'h0001);
    endproperty
    a_skip_gpr_one: assert property (p_skip_gpr_one) else $error("skip on one missed"); // [RL1]

    property p_skip_gpr_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_SKIP_GPR && !dif.pol) |-> (cond_hit == !gpr_src[dif.bsel]);
    endproperty
    a_skip_gpr_zero: assert property (p_skip_gpr_zero) else $error("skip on zero wrong"); // [RL2]

    property p_skip_io;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_SKIP_IO) |-> (cond_hit == (io_rdata[dif.bsel] == dif.pol));
    endproperty
    a_skip_io: assert property (p_skip_io) else $error("io skip wrong"); // [RL3]

    property p_skip_long;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_q == ST_SKIP && bslse_two_word(pm_word))
        |-> ##2 (state_q == ST_EXEC) && (pc_q == $past(pc_q, 2) + 16'h0002);
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("two-word skip length wrong"); // [RL4]

    property p_branch_taken;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_BRANCH && cond_hit)
        |=> (state_q == ST_BRANCH) && (pc_q == $past(pc_q) + $past(koff_ext) + 16'h0001)
        ##1 (state_q == ST_EXEC);
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong"); // [RL5]

    property p_branch_not_taken;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_BRANCH && !cond_hit)
        |=> (state_q == ST_EXEC) && (pc_q == $past(pc_q) + 16'h0001);
    endproperty
    a_branch_not_taken: assert property (p_branch_not_taken) else $error("untaken branch slow"); // [RL6]

    property p_branch_zero_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_BRANCH && dif.bsel == `BSLSE_FLAG_Z)
        |-> (cond_hit == (cpu_flag_word[`BSLSE_FLAG_Z] == dif.pol));
    endproperty
    a_branch_zero_flag: assert property (p_branch_zero_flag) else $error("equal branch wrong"); // [RL7]

    property p_branch_signed;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_BRANCH && dif.bsel == `BSLSE_FLAG_S)
        |-> (cond_hit == ((cpu_flag_word[`BSLSE_FLAG_N] ^ cpu_flag_word[`BSLSE_FLAG_V]) == dif.pol));
    endproperty
    a_branch_signed: assert property (p_branch_signed) else $error("signed branch wrong"); // [RL10]

    property p_load_two_cycles;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_LOAD) |=> dm_re && (state_q == ST_MEM) ##1 !dm_re && exec;
    endproperty
    a_load_two_cycles: assert property (p_load_two_cycles) else $error("load not two cycles"); // [RL15]

    property p_load_predec;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_LOAD && dif.amode == AM_PTR && dif.pmode == PM_DEC)
        |=> (dm_addr == $past(ptr_val) - 16'h0001);
    endproperty
    a_load_predec: assert property (p_load_predec) else $error("pre-decrement address wrong"); // [RL16]

    property p_load_disp;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_LOAD && dif.amode == AM_DISP)
        |=> (dm_addr == $past(ptr_val) + {10'h000, $past(dif.disp)}) && !ptr_wr_q;
    endproperty
    a_load_disp: assert property (p_load_disp) else $error("displaced load wrong"); // [RL17]

    property p_store_postinc;
        @(posedge ref_clk) disable iff (sys_rst)
        (exec && dif.op == OP_STORE && dif.amode == AM_PTR && dif.pmode == PM_INC)
        |=> dm_we && (dm_addr == $past(ptr_val)) && (ptr_new_q == $past(ptr_val) + 16'h0001);
    endproperty
    a_store_postinc: assert property (p_store_postinc) else $error("post-increment store wrong"); // [RL19]

    c_skip_long: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_SKIP ##1 state_q == ST_SKIP2);
    c_branch: cover property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_BRANCH);
    c_load: cover property (@(posedge ref_clk) disable iff (sys_rst)
        dm_re && direct_q);
    c_store: cover property (@(posedge ref_clk) disable iff (sys_rst)
        dm_we && ptr_wr_q);
endmodule

// [verif/bslse_dmem_model.sv]
// Purpose: Data memory and I/O register model facing the core.
// Assumes: Reads are combinational under dm_re; writes land at the edge.
// Notes: Idle read data shows the inverse of the last byte read.
`timescale 1ns/1ps
module bslse_dmem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] dm_addr,
    input  wire logic [7:0]  dm_wdata,
    input  wire logic        dm_we,
    input  wire logic        dm_re,
    output logic [7:0]       dm_rdata,
    input  wire logic [4:0]  io_addr,
    output logic [7:0]       io_rdata
);
    logic [7:0]  mem [0:255];
    logic [7:0]  io_regs [0:31];
    logic [7:0]  last_q = 8'h00;
    logic [15:0] last_addr_q = 16'h0000;
    always @(posedge ref_clk) begin
        if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
        if (dm_re) last_q <= mem[dm_addr[7:0]];
        if (dm_we || dm_re) last_addr_q <= dm_addr;
    end
    assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~last_q;
    assign io_rdata = io_regs[io_addr];
endmodule

// [verif/branch_skip_load_store_exec_bench.sv]
// Purpose: Self-checking bench for the branch, skip, load and store core.
// Assumes: Program memory is a bench array read at pm_addr.
// Notes: Every case restarts from reset, so register contents are known.
`timescale 1ns/1ps
module branch_skip_load_store_exec_bench;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] prog [0:255];
    logic [15:0] tr [1:5];
    logic [15:0] pm_addr, dm_addr, ea, pt;
    logic [7:0]  cpu_flag_word = 8'h00;
    logic [7:0]  dm_wdata, dm_rdata, io_rdata, dbg_data, v, w, got;
    logic [4:0]  io_addr;
    logic [4:0]  dbg_sel = 5'h00;
    logic [6:0]  k;
    logic [5:0]  q;
    logic [3:0]  ic;
    logic        dm_we, dm_re, unknown_op, c;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          p, m, b;
    wire  [15:0] pm_word = prog[pm_addr[7:0]];
    wire  [15:0] pm_next = prog[pm_addr[7:0] + 8'h01];
    bslse_core uut (.ref_clk, .sys_rst, .pm_addr, .pm_word, .pm_next, .cpu_flag_word,
        .io_addr, .io_rdata, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata, .dbg_sel,
        .dbg_data, .unknown_op);
    bslse_dmem_model dmem (.ref_clk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata,
        .io_addr, .io_rdata);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic cmp_pc(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        cmp_pc({8'h00, g}, {8'h00, e});
    endtask
    task automatic start();
        sys_rst = 1'b1;
        for (int i = 0; i < 256; i++) prog[i] = 16'h2c00;
    endtask
    task automatic run(input int n);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(negedge ref_clk);
            tr[i] = pm_addr;
        end
    endtask
    task automatic rd(input int r, output logic [7:0] x);
        dbg_sel = 5'(r);
        @(negedge ref_clk);
        x = dbg_data;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h6669));
        for (int i = 0; i < 256; i++) dmem.mem[i] = 8'($urandom);
        for (int i = 0; i < 32; i++) dmem.io_regs[i] = 8'($urandom);
        start();
        repeat (20) @(negedge ref_clk);
        // Bits 2:0 pick the flag, bit 3 its value, bit 4 the branch polarity.
        for (int t = 0; t < 64; t++) begin
            start();
            k = 7'($urandom);
            if (k == 7'h7f) k = 7'h00;
            cpu_flag_word = 8'($urandom);
            cpu_flag_word[t[2:0]] = t[3];
            if (t[2:0] == 3'h4) cpu_flag_word[2] = cpu_flag_word[3] ^ t[3];
            c = (t[3] == t[4]);
            prog[0] = {5'b11110, ~t[4], k, t[2:0]};
            run(3);
            ea = 16'h0001 + {{9{k[6]}}, k};
            cmp_pc(tr[1], c ? ea : 16'h0001);
            cmp_pc(tr[3], c ? ea + 16'h0001 : 16'h0003);
        end
        $display("branch test done");
        // Bits 1:0 pick the skip kind, bit 2 a two-word follower.
        for (int t = 0; t < 32; t++) begin
            start();
            v = 8'($urandom);
            w = 8'($urandom) | 8'h01;
            b = $urandom % 8;
            p = $urandom % 32;
            dmem.io_regs[p] = v;
            dmem.mem[p] = w;
            c = (v[b] == t[0]);
            prog[0] = {4'he, v[7:4], 4'h0, v[3:0]};
            prog[1] = t[1] ? {6'b100110, t[0], 1'b1, 5'(p), 3'(b)}
                           : {6'b111111, t[0], 5'h10, 1'b0, 3'(b)};
            prog[2] = t[2] ? 16'h9110 : {4'he, w[7:4], 4'h1, w[3:0]};
            prog[3] = t[2] ? 16'(p) : 16'h2c00;
            run(4);
            cmp_pc(tr[3], (c || !t[2]) ? 16'h0003 : 16'h0002);
            cmp_pc(tr[4], 16'h0004);
            rd(17, got);
            cmp_byte(got, c ? 8'h00 : w);
        end
        $display("skip test done");
        // Modes: 0 load inc, 1 load dec, 2 store inc, 3 store dec, 4 displaced, 5 direct.
        for (int t = 0; t < 36; t++) begin
            m = t % 6;
            p = (m == 4 && t / 6 % 3 == 0) ? 1 : t / 6 % 3;
            pt = {8'($urandom), t[0] ? 8'h00 : 8'($urandom)};
            q = 6'($urandom);
            v = 8'($urandom);
            ic = (p == 0) ? 4'hd : (p == 1) ? 4'h9 : 4'h1;
            if (m == 1 || m == 3) ic = ic + 4'h1;
            start();
            prog[0] = {4'he, pt[7:4], 4'(10 + 2 * p), pt[3:0]};
            prog[1] = {4'he, pt[15:12], 4'(11 + 2 * p), pt[11:8]};
            prog[2] = {4'he, v[7:4], 4'h1, v[3:0]};
            prog[3] = (m < 2) ? {12'h911, ic} : (m < 4) ? {12'h931, ic} : 16'h9110;
            if (m == 4) prog[3] = {2'b10, q[5], 1'b0, q[4:3], 1'b0, 5'h11, p == 1, q[2:0]};
            prog[4] = 16'(q);
            ea = (m == 1 || m == 3) ? pt - 16'h0001 : (m == 4) ? pt + 16'(q) : pt;
            if (m == 5) ea = 16'(q);
            w = dmem.mem[ea[7:0]];
            run(5);
            cmp_pc(tr[4], 16'h0003);
            cmp_pc(tr[5], (m == 5) ? 16'h0005 : 16'h0004);
            cmp_pc(dmem.last_addr_q, ea);
            rd(17, got);
            if (m == 2 || m == 3) got = dmem.mem[ea[7:0]];
            cmp_byte(got, (m == 2 || m == 3) ? v : w);
            pt = (m == 0 || m == 2) ? pt + 16'h0001 : (m == 1 || m == 3) ? ea : pt;
            rd(26 + 2 * p, got);
            cmp_byte(got, pt[7:0]);
            rd(27 + 2 * p, got);
            cmp_byte(got, pt[15:8]);
        end
        $display("load store test done");
        tally_and_finish();
    end
endmodule
